//--- rtl/ams_pkg.sv
// Summary of operation
// RL1: after reset, round-robin is selected and nothing converts until monitoring is enabled.
// RL2: monitor enable bit set starts conversions in the selected mode.
// RL3: round-robin order: supply, internal temp, external/inputs, input three, input four.
// RL4: third slot is external diode or inputs one and two, per pin setup.
// RL5: single-channel select bit leaves round-robin for single-channel operation.
// RL6: channel-select field picks channel; all zero selects the supply.
// RL7: field lowest bit one selects the internal temperature channel; the code selects it only for field value one.
// RL8: single-channel conversions follow each other with no idle gap.
// RL9: serial access halts conversion; converting resumes when access ends.
// RL10: internal temperature result is stored in twos complement.
// RL11: internal temperature offset is added before the result is stored.
// RL12: external temperature result is a ten-bit twos complement code.
// RL13: external temperature result averages sixteen successive measurements.
// RL14: supply result is ten-bit straight binary, 7 V gives full code.
// RL15: internal reference always used for supply and both temperature channels.
// RL16: output converter reference defaults to external after reset.
// RL17: reference amplifier powered only while monitoring is enabled.
// RL18: averaging on after reset; averaging-disable bit turns it off.
// RL19: mode or channel change abandons a conversion; next uses new setting.
package ams_pkg;

   // ****************************************
   // measurement channels
   // ****************************************
   typedef enum logic [2:0] {
      AMS_CH_VDD,
      AMS_CH_INT,
      AMS_CH_EXT,
      AMS_CH_ANALOG_INPUT_ONE,
      AMS_CH_ANALOG_INPUT_TWO,
      AMS_CH_ANALOG_INPUT_THREE,
      AMS_CH_ANALOG_INPUT_FOUR
   } ams_ch_e;

   // ****************************************
   // sizes, counts and reset values
   // ****************************************
   localparam int          AMS_CODE_W   = 10;
   localparam int          AMS_ACC_W    = 14;
   localparam int          AMS_AVG_SH   = 4;
   localparam logic [3:0]  AMS_AVG_LAST = 4'hF;
   localparam logic [9:0]  AMS_CODE_RST = 10'h000;
   localparam logic [13:0] AMS_ACC_RST  = 14'h0000;
   localparam logic [3:0]  AMS_CNT_RST  = 4'h0;
   localparam logic        AMS_DACREF_RST = 1'b0;

endpackage : ams_pkg

//--- rtl/ams_sequencer.sv
`timescale 1ns/1ps
module ams_sequencer (
   input  wire logic       mclk,            // 125 MHz clock
   input  wire logic       rst_n,           // sync reset, low
   input  wire logic       clk_en,          // freezes all state when low
   input  wire logic       monitor_enable_bit,        // conversions on
   input  wire logic       single_channel_select_bit, // 1: single mode
   input  wire logic [2:0] channel_select_field,      // single channel
   input  wire logic       avg_disable,     // 1: no averaging
   input  wire logic       ext_sensor_mode, // 1: shared pins are diode
   input  wire logic       ain_ref_internal, // ref for analog inputs
   input  wire logic       dac_ref_sel,     // 1: internal dac ref
   input  wire logic [7:0] int_temp_offset, // signed, quarter degrees
   input  wire logic       serial_busy,     // serial access active
   input  wire logic       afe_done,        // conversion finished
   input  wire logic [9:0] afe_code,        // raw converter code
   output logic            afe_conv_start,  // start pulse
   output logic            afe_reset,       // abandon pulse
   output logic [2:0]      afe_channel,     // mux select
   output logic            afe_int_ref,     // 1: internal reference
   output logic            ref_amp_pwr,     // reference amp power
   output logic            dac_ref_internal, // dac reference select
   output logic            result_wr,       // a value was updated
   output logic [9:0]      vdd_value,       // straight binary
   output logic [9:0]      int_temp_value,  // twos complement
   output logic [9:0]      ext_temp_value,  // twos complement
   output logic [9:0]      analog_input_one_value,      // straight binary
   output logic [9:0]      analog_input_two_value,      // straight binary
   output logic [9:0]      analog_input_three_value,      // straight binary
   output logic [9:0]      analog_input_four_value       // straight binary
);

   // ****************************************
   // sequencer state
   // ****************************************
   typedef enum logic {
      AMS_IDLE,
      AMS_CONV
   } ams_st_e;

   ams_st_e              st_q, st_d;
   ams_pkg::ams_ch_e     ch_q, ch_d;
   logic [3:0]           cnt_q, cnt_d;
   logic signed [13:0]   acc_q, acc_d;
   logic                 start_q, start_d;
   logic                 abort_q, abort_d;
   logic                 iref_q, iref_d;
   logic                 pwr_q, pwr_d;
   logic                 dref_q, dref_d;
   logic                 wr_q, wr_d;
   logic [4:0]           cfg_q, cfg_d;
   logic [9:0]           val_q [7];
   logic [9:0]           val_d [7];

   logic                 run;
   logic                 cfg_chg;
   logic                 avg_on;
   logic signed [13:0]   sum;
   logic signed [13:0]   res;
   ams_pkg::ams_ch_e     sel_ch;
   ams_pkg::ams_ch_e     nxt_ch;

   // ****************************************
   // channel choice
   // ****************************************
   always_comb begin
      // codes above the last input fall back to the supply
      sel_ch = ams_pkg::AMS_CH_VDD;                                // [RL6]
      if (channel_select_field <= 3'h6) begin
         sel_ch = ams_pkg::ams_ch_e'(channel_select_field);        // [RL7]
      end
      nxt_ch = ams_pkg::AMS_CH_VDD;
      if (single_channel_select_bit) begin
         nxt_ch = sel_ch;                                          // [RL8]
      end else begin
         unique case (ch_q)                                        // [RL3]
            ams_pkg::AMS_CH_VDD:  nxt_ch = ams_pkg::AMS_CH_INT;
            ams_pkg::AMS_CH_INT:  nxt_ch = ext_sensor_mode ?       // [RL4]
                                     ams_pkg::AMS_CH_EXT :
                                     ams_pkg::AMS_CH_ANALOG_INPUT_ONE;
            ams_pkg::AMS_CH_EXT:  nxt_ch = ams_pkg::AMS_CH_ANALOG_INPUT_THREE;
            ams_pkg::AMS_CH_ANALOG_INPUT_ONE: nxt_ch = ams_pkg::AMS_CH_ANALOG_INPUT_TWO;
            ams_pkg::AMS_CH_ANALOG_INPUT_TWO: nxt_ch = ams_pkg::AMS_CH_ANALOG_INPUT_THREE;
            ams_pkg::AMS_CH_ANALOG_INPUT_THREE: nxt_ch = ams_pkg::AMS_CH_ANALOG_INPUT_FOUR;
            ams_pkg::AMS_CH_ANALOG_INPUT_FOUR: nxt_ch = ams_pkg::AMS_CH_VDD;
            default:              nxt_ch = ams_pkg::AMS_CH_VDD;
         endcase
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      run     = monitor_enable_bit && !serial_busy;                // [RL2] [RL9]
      cfg_d   = {single_channel_select_bit, channel_select_field,
                 ext_sensor_mode};
      cfg_chg = (cfg_d != cfg_q);
      avg_on  = !avg_disable &&                                    // [RL18]
                (ch_q == ams_pkg::AMS_CH_INT ||
                 ch_q == ams_pkg::AMS_CH_EXT);                     // [RL13]
      sum     = acc_q + 14'(signed'(afe_code));
      res     = avg_on ? (sum >>> ams_pkg::AMS_AVG_SH)
                       : 14'(signed'(afe_code));
      if (ch_q == ams_pkg::AMS_CH_INT) begin
         res = res + 14'(signed'(int_temp_offset));                // [RL11]
      end
      st_d    = st_q;
      ch_d    = ch_q;
      cnt_d   = cnt_q;
      acc_d   = acc_q;
      start_d = 1'b0;
      abort_d = 1'b0;
      wr_d    = 1'b0;
      val_d   = val_q;
      if (!run || cfg_chg) begin
         // serial access or new setting: drop the partial average
         st_d    = AMS_IDLE;
         cnt_d   = ams_pkg::AMS_CNT_RST;
         acc_d   = ams_pkg::AMS_ACC_RST;
         abort_d = (st_q == AMS_CONV);                             // [RL9] [RL19]
         if (cfg_chg) begin
            ch_d = single_channel_select_bit ? sel_ch             // [RL5]
                                             : ams_pkg::AMS_CH_VDD;// [RL19]
         end
      end else begin
         unique case (st_q)
            AMS_IDLE: begin
               st_d    = AMS_CONV;
               start_d = 1'b1;                                     // [RL2]
            end
            AMS_CONV: begin
               if (afe_done) begin
                  start_d = 1'b1;                                  // [RL8]
                  if (avg_on && cnt_q != ams_pkg::AMS_AVG_LAST) begin
                     cnt_d = cnt_q + 4'h1;
                     acc_d = sum;
                  end else begin
                     cnt_d = ams_pkg::AMS_CNT_RST;
                     acc_d = ams_pkg::AMS_ACC_RST;
                     wr_d  = 1'b1;
                     // temps keep sign bit, others are plain binary
                     val_d[ch_q] = res[9:0];                       // [RL10] [RL12] [RL14]
                     ch_d  = nxt_ch;                               // [RL3]
                  end
               end
            end
         endcase
      end
      iref_d = (ch_d == ams_pkg::AMS_CH_VDD ||
                ch_d == ams_pkg::AMS_CH_INT ||
                ch_d == ams_pkg::AMS_CH_EXT) ? 1'b1
                                             : ain_ref_internal;   // [RL15]
      pwr_d  = monitor_enable_bit;                                 // [RL17]
      dref_d = dac_ref_sel;                                        // [RL16]
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q    <= AMS_IDLE;                                      // [RL1]
         ch_q    <= ams_pkg::AMS_CH_VDD;                           // [RL1]
         cnt_q   <= ams_pkg::AMS_CNT_RST;
         acc_q   <= ams_pkg::AMS_ACC_RST;
         start_q <= 1'b0;
         abort_q <= 1'b0;
         iref_q  <= 1'b1;
         pwr_q   <= 1'b0;
         dref_q  <= ams_pkg::AMS_DACREF_RST;                       // [RL16]
         wr_q    <= 1'b0;
         cfg_q   <= 5'h00;
         for (int i = 0; i < 7; i++) begin
            val_q[i] <= ams_pkg::AMS_CODE_RST;
         end
      end else if (clk_en) begin
         st_q    <= st_d;
         ch_q    <= ch_d;
         cnt_q   <= cnt_d;
         acc_q   <= acc_d;
         start_q <= start_d;
         abort_q <= abort_d;
         iref_q  <= iref_d;
         pwr_q   <= pwr_d;
         dref_q  <= dref_d;
         wr_q    <= wr_d;
         cfg_q   <= cfg_d;
         val_q   <= val_d;
      end
   end

   assign afe_conv_start   = start_q;
   assign afe_reset        = abort_q;
   assign afe_channel      = ch_q;
   assign afe_int_ref      = iref_q;
   assign ref_amp_pwr      = pwr_q;
   assign dac_ref_internal = dref_q;
   assign result_wr        = wr_q;
   assign vdd_value        = val_q[0];
   assign int_temp_value   = val_q[1];
   assign ext_temp_value   = val_q[2];
   assign analog_input_one_value       = val_q[3];
   assign analog_input_two_value       = val_q[4];
   assign analog_input_three_value       = val_q[5];
   assign analog_input_four_value       = val_q[6];

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_idle_disabled: assert property ( // [RL1]
      clk_en && !monitor_enable_bit |=> !afe_conv_start)
      else $error("conversion started while disabled");
   a_enable_starts: assert property ( // [RL2]
      clk_en && st_q == AMS_IDLE && run && !cfg_chg |=> afe_conv_start)
      else $error("enable did not start a conversion");
   a_rr_order: assert property ( // [RL3]
      clk_en && wr_d && !single_channel_select_bit &&
      ch_q == ams_pkg::AMS_CH_ANALOG_INPUT_FOUR |=> ch_q == ams_pkg::AMS_CH_VDD)
      else $error("round robin did not wrap");
   a_third_slot: assert property ( // [RL4]
      clk_en && wr_d && !single_channel_select_bit && ext_sensor_mode &&
      ch_q == ams_pkg::AMS_CH_INT |=> ch_q == ams_pkg::AMS_CH_EXT)
      else $error("third slot wrong");
   a_single_hold: assert property ( // [RL6]
      clk_en && wr_d && single_channel_select_bit && !cfg_chg &&
      channel_select_field == 3'h0 |=> ch_q == ams_pkg::AMS_CH_VDD)
      else $error("single channel moved off supply");
   a_no_gap: assert property ( // [RL8]
      clk_en && run && !cfg_chg && st_q == AMS_CONV && afe_done
      |=> afe_conv_start)
      else $error("gap between conversions");
   a_serial_halt: assert property ( // [RL9]
      clk_en && serial_busy && st_q == AMS_CONV |=> afe_reset)
      else $error("serial access did not halt");
   a_avg_count: assert property ( // [RL13]
      clk_en && wr_d && avg_on |-> cnt_q == ams_pkg::AMS_AVG_LAST)
      else $error("average written early");
   a_int_ref: assert property ( // [RL15]
      (ch_q == ams_pkg::AMS_CH_VDD || ch_q == ams_pkg::AMS_CH_INT) &&
      $stable(ch_q) |-> afe_int_ref)
      else $error("internal reference not used");
   a_amp_power: assert property ( // [RL17]
      clk_en && !monitor_enable_bit |=> !ref_amp_pwr)
      else $error("reference amp powered while disabled");
   a_cfg_abort: assert property ( // [RL19]
      clk_en && cfg_chg && st_q == AMS_CONV |=> afe_reset && st_q == AMS_IDLE)
      else $error("setting change did not abandon");

   // ****************************************
   // mode, format and reference checks
   // ****************************************
   // a new setting moves the mux one cycle later
   a_mode_single: assert property ( // [RL5]
      clk_en && cfg_chg && single_channel_select_bit &&
      channel_select_field == 3'h3 |=> ch_q == ams_pkg::AMS_CH_ANALOG_INPUT_ONE)
      else $error("single mode did not take the field");

   a_pick_vdd: assert property ( // [RL6]
      clk_en && cfg_chg && single_channel_select_bit &&
      channel_select_field == 3'h0 |=> ch_q == ams_pkg::AMS_CH_VDD)
      else $error("zero field did not pick supply");

   a_pick_int: assert property ( // [RL7]
      clk_en && cfg_chg && single_channel_select_bit &&
      channel_select_field == 3'h1 |=> ch_q == ams_pkg::AMS_CH_INT)
      else $error("field one did not pick internal temp");

   a_rr_restart: assert property ( // [RL19]
      clk_en && cfg_chg && !single_channel_select_bit
      |=> ch_q == ams_pkg::AMS_CH_VDD && cnt_q == ams_pkg::AMS_CNT_RST)
      else $error("round robin did not restart at supply");

   // a short access may end the next cycle, so only starts are checked
   a_busy_nostart: assert property ( // [RL9]
      clk_en && serial_busy |=> !afe_conv_start)
      else $error("conversion started during serial access");

   // results land one cycle after the write strobe
   a_int_sign: assert property ( // [RL10]
      clk_en && wr_d && ch_q == ams_pkg::AMS_CH_INT && !avg_on &&
      int_temp_offset == 8'h00 |=> int_temp_value == $past(afe_code))
      else $error("internal temp code not kept signed");

   a_int_offset: assert property ( // [RL11]
      clk_en && wr_d && ch_q == ams_pkg::AMS_CH_INT && !avg_on
      |=> int_temp_value == $past(afe_code) +
          {{2{$past(int_temp_offset[7])}}, $past(int_temp_offset)})
      else $error("internal temp offset not added");

   a_ext_code: assert property ( // [RL12]
      clk_en && wr_d && ch_q == ams_pkg::AMS_CH_EXT && !avg_on
      |=> ext_temp_value == $past(afe_code))
      else $error("external temp code wrong");

   a_vdd_binary: assert property ( // [RL14]
      clk_en && wr_d && ch_q == ams_pkg::AMS_CH_VDD
      |=> vdd_value == $past(afe_code))
      else $error("supply code not straight binary");

   // a stale sum would leak into the next channel's average
   a_avg_restart: assert property ( // [RL13]
      clk_en && wr_d && avg_on
      |=> cnt_q == ams_pkg::AMS_CNT_RST && acc_q == ams_pkg::AMS_ACC_RST)
      else $error("average not restarted after result");

   a_avg_off: assert property ( // [RL18]
      clk_en && run && !cfg_chg && st_q == AMS_CONV && afe_done &&
      avg_disable |-> wr_d)
      else $error("result averaged while averaging off");

   // reference follows the channel, never lags it
   a_ext_ref: assert property ( // [RL15]
      clk_en && ch_d == ams_pkg::AMS_CH_EXT |=> afe_int_ref)
      else $error("external temp without internal reference");

   // dac reference is only a registered copy of the select
   a_dac_ref: assert property ( // [RL16]
      clk_en |=> dac_ref_internal == $past(dac_ref_sel))
      else $error("dac reference select not taken");

   a_amp_on: assert property ( // [RL17]
      clk_en && monitor_enable_bit |=> ref_amp_pwr)
      else $error("reference amp off while monitoring");

   a_cfg_flush: assert property ( // [RL19]
      clk_en && cfg_chg |=> cnt_q == ams_pkg::AMS_CNT_RST && !afe_conv_start)
      else $error("setting change kept partial average");

   c_rr_wrap:  cover property (wr_d && ch_q == ams_pkg::AMS_CH_ANALOG_INPUT_FOUR);
   c_avg_done: cover property (wr_d && ch_q == ams_pkg::AMS_CH_EXT && avg_on);
   c_serial:   cover property (abort_q && serial_busy);
   c_single:   cover property (wr_d && single_channel_select_bit);
   c_cfg_drop: cover property (abort_q && !serial_busy);

endmodule : ams_sequencer

//--- testbench/ams_afe_model.sv
`timescale 1ns/1ps
// ****************************************
// front end and converter model
// ****************************************
module ams_afe_model (
   input  wire logic       mclk,       // clock
   input  wire logic       rst_n,      // sync reset, low
   input  wire logic       conv_start, // start pulse
   input  wire logic       conv_abort, // abandon pulse
   input  wire logic [7:0] lat,        // countdown, done comes lat+2 cycles after start
   input  wire logic [9:0] code_in,    // code to return
   output logic            done,       // done pulse
   output logic [9:0]      code        // valid with done only
);
   logic       busy_q;
   logic [7:0] cnt_q;
   initial code = 10'h155;
   always @(posedge mclk) begin
      done <= 1'b0;
      // stale code flips so a late sample cannot pass for valid
      code <= ~code;
      if (!rst_n || conv_abort) begin
         busy_q <= 1'b0;
      end else if (conv_start) begin
         busy_q <= 1'b1;
         cnt_q  <= lat;
      end else if (busy_q && cnt_q == 8'h00) begin
         busy_q <= 1'b0;
         done   <= 1'b1;
         code   <= code_in;
      end else begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule : ams_afe_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic       mclk, rst_n, clk_en, monitor_enable_bit, avg_disable;
   logic       single_channel_select_bit, ext_sensor_mode, serial_busy;
   logic       ain_ref_internal, dac_ref_sel, afe_done, afe_conv_start;
   logic       afe_reset, afe_int_ref, ref_amp_pwr, dac_ref_internal, result_wr;
   logic [2:0] channel_select_field, afe_channel;
   logic [7:0] int_temp_offset, lat;
   logic [9:0] code_in, afe_code, vdd_value, int_temp_value;
   logic [9:0] ext_temp_value, analog_input_one_value, analog_input_two_value, analog_input_three_value, analog_input_four_value;
   int         err_count = 0;
   int         n_tests = 0;

   ams_sequencer dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
      .monitor_enable_bit(monitor_enable_bit),
      .single_channel_select_bit(single_channel_select_bit),
      .channel_select_field(channel_select_field),
      .avg_disable(avg_disable), .ext_sensor_mode(ext_sensor_mode),
      .ain_ref_internal(ain_ref_internal), .dac_ref_sel(dac_ref_sel),
      .int_temp_offset(int_temp_offset), .serial_busy(serial_busy),
      .afe_done(afe_done), .afe_code(afe_code),
      .afe_conv_start(afe_conv_start), .afe_reset(afe_reset),
      .afe_channel(afe_channel), .afe_int_ref(afe_int_ref),
      .ref_amp_pwr(ref_amp_pwr), .dac_ref_internal(dac_ref_internal),
      .result_wr(result_wr), .vdd_value(vdd_value),
      .int_temp_value(int_temp_value),
      .ext_temp_value(ext_temp_value), .analog_input_one_value(analog_input_one_value),
      .analog_input_two_value(analog_input_two_value), .analog_input_three_value(analog_input_three_value),
      .analog_input_four_value(analog_input_four_value));
   ams_afe_model afe_u (.mclk(mclk), .rst_n(rst_n),
      .conv_start(afe_conv_start), .conv_abort(afe_reset), .lat(lat),
      .code_in(code_in), .done(afe_done), .code(afe_code));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge mclk);
   endtask : step
   task automatic wait_hi(ref logic s, input int lim);
      int i;
      for (i = 0; i < lim && s !== 1'b1; i++) @(negedge mclk);
      chk({9'h000, s}, 10'h001);
   endtask : wait_hi
   task automatic wait_start(output logic [2:0] ch, output logic r);
      wait_hi(afe_conv_start, 400);
      ch = afe_channel;
      r = afe_int_ref;
      step(1);
   endtask : wait_start
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      repeat (10) begin
         step(1);
         chk(afe_conv_start, 1'b0);
      end
      chk(ref_amp_pwr, 1'b0);
      chk(dac_ref_internal, 1'b0);
      dac_ref_sel = 1'b1;
      step(2);
      chk(dac_ref_internal, 1'b1);
   endtask : t_reset

   // exp holds the slot channels after supply, lowest slot first
   task automatic t_rr(input logic ext, input int n, input logic [14:0] exp);
      logic [2:0] ch, prev;
      logic       r;
      int         reps, k;
      ext_sensor_mode = ext;
      avg_disable = !ext;
      ain_ref_internal = ext;
      monitor_enable_bit = 1'b1;
      wait_start(ch, r);
      chk(ch, ams_pkg::AMS_CH_VDD);
      chk(ref_amp_pwr, 1'b1);
      reps = 1;
      k = 0;
      while (k <= n) begin
         prev = ch;
         wait_start(ch, r);
         if (ch === prev) begin
            reps++;
         end else begin
            if (k < n) chk(ch, exp[3*k +: 3]);
            else chk(ch, ams_pkg::AMS_CH_VDD);
            if (prev === ams_pkg::AMS_CH_INT) chk(reps, ext ? 16 : 1);
            reps = 1;
            k++;
         end
         if (ch < ams_pkg::AMS_CH_ANALOG_INPUT_ONE) chk(r, 1'b1);
         else chk(r, ain_ref_internal);
      end
      chk(vdd_value, 10'h3E0);
      chk(int_temp_value, 10'h3DC);
      if (ext) chk(ext_temp_value, 10'h3E0);
      else chk(analog_input_one_value, 10'h3E0);
      if (!ext) chk(analog_input_two_value, 10'h3E0);
      chk(analog_input_three_value, 10'h3E0);
      chk(analog_input_four_value, 10'h3E0);
      monitor_enable_bit = 1'b0;
      step(3);
      chk(ref_amp_pwr, 1'b0);
   endtask : t_rr

   task automatic t_single;
      logic [2:0] ch;
      logic       r;
      lat = 8'h00;
      single_channel_select_bit = 1'b1;
      monitor_enable_bit = 1'b1;
      for (int f = 0; f < 8; f++) begin
         channel_select_field = 3'(f);
         step(1);
         wait_start(ch, r);
         chk(ch, (f == 7) ? 10'h000 : 10'(f));
         wait_hi(afe_done, 50);
         step(1);
         chk(afe_conv_start, 1'b1);
         chk(result_wr, 1'b1);
      end
      lat = 8'h14;
      channel_select_field = 3'h1;
      step(4);
      wait_start(ch, r);
      channel_select_field = 3'h5;
      wait_hi(afe_reset, 4);
      wait_start(ch, r);
      chk(ch, ams_pkg::AMS_CH_ANALOG_INPUT_THREE);
      serial_busy = 1'b1;
      wait_hi(afe_reset, 4);
      repeat (10) begin
         step(1);
         chk(afe_conv_start, 1'b0);
      end
      serial_busy = 1'b0;
      wait_hi(afe_conv_start, 4);
      chk(afe_channel, ams_pkg::AMS_CH_ANALOG_INPUT_THREE);
   endtask : t_single

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      #(8 * 20000);
      err_count++;
      finish_test;
   end
   initial begin
      {rst_n, monitor_enable_bit, single_channel_select_bit} = 3'h0;
      {avg_disable, serial_busy, dac_ref_sel, ain_ref_internal} = 4'h0;
      {clk_en, ext_sensor_mode} = 2'h3;
      channel_select_field = 3'h0;
      int_temp_offset = 8'hFC;
      lat = 8'h03;
      code_in = 10'h3E0;
      step(6);
      rst_n = 1'b1;
      t_reset;
      t_rr(1'b1, 4, {3'h0, ams_pkg::AMS_CH_ANALOG_INPUT_FOUR, ams_pkg::AMS_CH_ANALOG_INPUT_THREE,
         ams_pkg::AMS_CH_EXT, ams_pkg::AMS_CH_INT});
      t_rr(1'b0, 5, {ams_pkg::AMS_CH_ANALOG_INPUT_FOUR, ams_pkg::AMS_CH_ANALOG_INPUT_THREE,
         ams_pkg::AMS_CH_ANALOG_INPUT_TWO, ams_pkg::AMS_CH_ANALOG_INPUT_ONE, ams_pkg::AMS_CH_INT});
      t_single;
      finish_test;
   end
endmodule : tb_top
